/* File: inc/ipf_pkg.sv */
// Types shared by the input conditioning block.
package ipf_pkg;

  typedef enum logic [2:0] {IPF_PAR_NONE, IPF_PAR_ODD, IPF_PAR_EVEN, IPF_PAR_MARK,
                            IPF_PAR_SPACE} ipf_par_e;

  typedef logic [3:0] ipf_baud_t;

  typedef struct packed {
    logic [15:0] link_addr;
    logic [15:0] tsync_s;
    logic [8:0]  pkt_wait;
    ipf_baud_t   baud;
    ipf_par_e    parity;
    logic        stop2;
    logic        la2;
    logic        ca2;
    logic        cot2;
    logic [1:0]  ioa_size;
  } ipf_link_cfg_s;

  typedef struct packed {
    logic       vld;
    logic       err;
    logic [1:0] val;
  } ipf_resp_s;

endpackage

/* File: inc/ipf_regs.svh */
// Register offsets, field positions, reset values and timing counts of the input block.
`ifndef IPF_REGS_SVH
`define IPF_REGS_SVH

`define IPF_OFF_LINK_ADDR  8'h00
`define IPF_OFF_TSYNC      8'h04
`define IPF_OFF_PKT_WAIT   8'h08
`define IPF_OFF_BAUD       8'h0c
`define IPF_OFF_FRAME      8'h10
`define IPF_OFF_INVERT     8'h14
`define IPF_OFF_GROUP      8'h18
`define IPF_OFF_SWAP       8'h1c
`define IPF_OFF_STATE      8'h20
`define IPF_OFF_DPAIR      8'h24
`define IPF_OFF_ISTAT      8'h28
`define IPF_OFF_IMASK      8'h2c
`define IPF_OFF_FILT_LO    8'h40
`define IPF_OFF_FILT_HI    8'h7c

`define IPF_FRM_PAR_LSB    0
`define IPF_FRM_PAR_MSB    2
`define IPF_FRM_STOP2      3
`define IPF_FRM_LA2        4
`define IPF_FRM_CA2        5
`define IPF_FRM_COT2       6
`define IPF_FRM_IOA_LSB    8
`define IPF_FRM_IOA_MSB    9

`define IPF_EV_CHANGE      0
`define IPF_EV_CFG_REFUSED 1
`define IPF_EV_REQ_ERR     2

`define IPF_RST_LINK_ADDR  16'h0001
`define IPF_LINK_ADDR_1OCT 16'h0100
`define IPF_RST_TSYNC      16'h012c
`define IPF_RST_PKT_WAIT   9'h008
`define IPF_MIN_PKT_WAIT   9'h008
`define IPF_MAX_PKT_WAIT   9'h100
`define IPF_RST_BAUD       4'h5
`define IPF_MAX_BAUD       4'ha
`define IPF_RST_PARITY     3'h2
`define IPF_MAX_PARITY     3'h4
`define IPF_RST_IOA        2'h2
`define IPF_RST_FILT_MS    16'h0032

`define IPF_MS_NS          1000000
`define IPF_CLK_NS         8

`endif

/* File: logic/ipf_filt_mem.sv */
// Filter time store: one write port, two registered read ports, reset value per word.
`timescale 1ns/1ps
`include "ipf_regs.svh"
module ipf_filt_mem #(
  parameter int DEPTH = 16,
  parameter int DW    = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read ports
  input  wire logic [AW-1:0] raddr_a,
  output logic      [DW-1:0] rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [DW-1:0] rdata_b
);
  logic [DW-1:0]    mem [DEPTH];
  logic [DEPTH-1:0] written_r;

  initial begin
    if (DEPTH > (1 << AW) || DW != 16) $error("ipf_filt_mem: bad geometry");
  end

  // Words never written read as the default, so the array itself needs no reset.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      written_r <= '0;
    end else if (we) begin
      written_r[waddr] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= written_r[raddr_a] ? mem[raddr_a] : `IPF_RST_FILT_MS;
      rdata_b <= written_r[raddr_b] ? mem[raddr_b] : `IPF_RST_FILT_MS;
    end
  end
endmodule

/* File: logic/ipf_pair.sv */
// Double-point encoder for one odd/even input pair.
`timescale 1ns/1ps
module ipf_pair (
  // Reported single states of the pair
  input  wire logic       first_input_of_pair,
  input  wire logic       second_input_of_pair,
  // Pair settings
  input  wire logic       swap,
  // Double-point value: 00 indeterminate, 01 off, 10 on, 11 error
  output logic      [1:0] double_point_pair
);
  // Unswapped, the first input means off (bit 0) and the second means on (bit 1).
  assign double_point_pair = swap ? {first_input_of_pair, second_input_of_pair}
                                  : {second_input_of_pair, first_input_of_pair};
endmodule

/* File: logic/ipf_top.sv */
// Input filter, inversion, pairing and link parameter block with register port.
//
// Functional notes
// - Link address 1 to 65535, default 1; above 256 needs two-octet address field.
// - Time sync timeout 1 to 65535 seconds, default 300.
// - Packet wait 8 to 256 bit times, default 8.
// - Baud index selects 600 to 115200 baud, default 19200.
// - Parity none, odd, even, mark, space, default even; one or two stop bits.
// - Address, common address, cause fields 1 or 2 octets; object address 1 to 3.
// - Only pairs starting at an odd input may be grouped.
// - Requests to the second input of a grouped pair are answered with error.
// - Pair value: 00 indeterminate, 01 off, 10 on, 11 error.
// - Active first input means off, active second input means on.
// - Per-pair swap exchanges the two inputs before encoding.
// - Inverted input reports 1 when inactive and 0 when active.
// - Indicator LED follows the physical input regardless of inversion.
// - A change is reported only after staying stable for the filter time.
// - Filter time defaults to 50 ms for every input.
`timescale 1ns/1ps
`include "ipf_regs.svh"
module ipf_top #(
  parameter int unsigned N_IN      = 16,
  parameter int unsigned MS_CYCLES = `IPF_MS_NS / `IPF_CLK_NS
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Input pins and indicators
  input  wire logic [N_IN-1:0]        din,
  output logic      [N_IN-1:0]        led,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // State requests from the protocol side
  input  wire logic                   req,
  input  wire logic [3:0]             req_idx,
  output ipf_pkg::ipf_resp_s          resp,
  // Reported states and link settings
  output logic      [N_IN-1:0]        single_state,
  output logic      [N_IN-1:0]        dp_state,
  output logic                        state_chg,
  output ipf_pkg::ipf_link_cfg_s      link_cfg,
  output logic                        irq
);
  localparam int NP = N_IN / 2;

  initial begin
    if (N_IN != 16) $error("ipf_top: register layout serves exactly 16 inputs");
    // A channel is visited once per N_IN cycles and keeps a single pending tick, so a
    // shorter millisecond would silently lose ticks and stretch every filter time.
    if (MS_CYCLES < N_IN || MS_CYCLES > 1000000) $error("ipf_top: MS_CYCLES out of range");
  end

  function automatic logic la_ok(input logic [15:0] addr, input logic la2);
    return (addr != 16'h0000) && (la2 || addr <= `IPF_LINK_ADDR_1OCT);
  endfunction

  function automatic logic hit(input logic [7:0] off);
    return reg_addr == off;
  endfunction

  // Input synchronisers and indicators.
  logic [N_IN-1:0] sync1_r, sync2_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      led     <= '0;
    end else begin
      sync1_r <= din;
      sync2_r <= sync1_r;
      led     <= sync2_r;
    end
  end

  // Configuration registers.
  ipf_pkg::ipf_link_cfg_s cfg_r;
  logic [N_IN-1:0] inv_r;
  logic [NP-1:0]   grp_r, swp_r;
  logic [2:0]      ev_mask_r;
  logic            cfg_refused;
  logic            filt_we;
  logic [3:0]      filt_waddr;
  logic [8:0]      pw_w;

  assign pw_w       = reg_wdata[8:0];
  assign filt_we    = reg_wr && reg_addr >= `IPF_OFF_FILT_LO && reg_addr <= `IPF_OFF_FILT_HI
                      && reg_addr[1:0] == 2'b00;
  assign filt_waddr = reg_addr[5:2];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r.link_addr <= `IPF_RST_LINK_ADDR;
      cfg_r.tsync_s   <= `IPF_RST_TSYNC;
      cfg_r.pkt_wait  <= `IPF_RST_PKT_WAIT;
      cfg_r.baud      <= `IPF_RST_BAUD;
      cfg_r.parity    <= ipf_pkg::ipf_par_e'(`IPF_RST_PARITY);
      cfg_r.stop2     <= 1'b0;
      cfg_r.la2       <= 1'b0;
      cfg_r.ca2       <= 1'b0;
      cfg_r.cot2      <= 1'b0;
      cfg_r.ioa_size  <= `IPF_RST_IOA;
      cfg_refused     <= 1'b0;
    end else begin
      cfg_refused <= 1'b0;
      if (reg_wr && hit(`IPF_OFF_LINK_ADDR)) begin
        if (la_ok(reg_wdata[15:0], cfg_r.la2)) cfg_r.link_addr <= reg_wdata[15:0];
        else cfg_refused <= 1'b1;
      end else if (reg_wr && hit(`IPF_OFF_TSYNC)) begin
        if (reg_wdata[15:0] != 16'h0000) cfg_r.tsync_s <= reg_wdata[15:0];
        else cfg_refused <= 1'b1;
      end else if (reg_wr && hit(`IPF_OFF_PKT_WAIT)) begin
        if (reg_wdata[31:9] == '0 && pw_w >= `IPF_MIN_PKT_WAIT && pw_w <= `IPF_MAX_PKT_WAIT)
          cfg_r.pkt_wait <= pw_w;
        else cfg_refused <= 1'b1;
      end else if (reg_wr && hit(`IPF_OFF_BAUD)) begin
        if (reg_wdata[31:4] == '0 && reg_wdata[3:0] <= `IPF_MAX_BAUD)
          cfg_r.baud <= reg_wdata[3:0];
        else cfg_refused <= 1'b1;
      end else if (reg_wr && hit(`IPF_OFF_FRAME)) begin
        // The whole word is refused if any field is illegal, so fields never mix.
        if (reg_wdata[`IPF_FRM_PAR_MSB:`IPF_FRM_PAR_LSB] <= `IPF_MAX_PARITY
            && reg_wdata[`IPF_FRM_IOA_MSB:`IPF_FRM_IOA_LSB] != 2'b00
            && la_ok(cfg_r.link_addr, reg_wdata[`IPF_FRM_LA2])) begin
          cfg_r.parity   <= ipf_pkg::ipf_par_e'(reg_wdata[`IPF_FRM_PAR_MSB:`IPF_FRM_PAR_LSB]);
          cfg_r.stop2    <= reg_wdata[`IPF_FRM_STOP2];
          cfg_r.la2      <= reg_wdata[`IPF_FRM_LA2];
          cfg_r.ca2      <= reg_wdata[`IPF_FRM_CA2];
          cfg_r.cot2     <= reg_wdata[`IPF_FRM_COT2];
          cfg_r.ioa_size <= reg_wdata[`IPF_FRM_IOA_MSB:`IPF_FRM_IOA_LSB];
        end else cfg_refused <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inv_r     <= '0;
      grp_r     <= '0;
      swp_r     <= '0;
      ev_mask_r <= '0;
    end else if (reg_wr) begin
      if (hit(`IPF_OFF_INVERT)) inv_r <= reg_wdata[N_IN-1:0];
      else if (hit(`IPF_OFF_GROUP)) grp_r <= reg_wdata[NP-1:0];
      else if (hit(`IPF_OFF_SWAP)) swp_r <= reg_wdata[NP-1:0];
      else if (hit(`IPF_OFF_IMASK)) ev_mask_r <= reg_wdata[2:0];
    end
  end

  assign link_cfg = cfg_r;

  // Filter time store and scan.
  logic [15:0] filt_rd, scan_ft;
  logic [3:0]  scan_r, scan_d_r;
  ipf_filt_mem #(.DEPTH(N_IN), .DW(16), .AW(4)) u_fmem (
    .clk     (clk),
    .nrst    (nrst),
    .we      (filt_we),
    .waddr   (filt_waddr),
    .wdata   (reg_wdata[15:0]),
    .raddr_a (filt_waddr),
    .rdata_a (filt_rd),
    .raddr_b (scan_r),
    .rdata_b (scan_ft)
  );

  // Millisecond time base.
  logic [19:0] ms_cnt_r;
  logic        ms_tick;
  assign ms_tick = ms_cnt_r == 20'(MS_CYCLES - 1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ms_cnt_r <= '0;
    else ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 20'h00001;
  end

  // One channel is checked per cycle, so a pulse shorter than a scan round of
  // 16 cycles may go unseen; that is far below any millisecond filter time.
  logic [15:0]     ms_cnt [N_IN];
  logic [N_IN-1:0] tick_seen_r, filt_r;
  logic            acc_hit;
  assign acc_hit = sync2_r[scan_d_r] != filt_r[scan_d_r] && ms_cnt[scan_d_r] >= scan_ft;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scan_r   <= '0;
      scan_d_r <= '0;
    end else begin
      scan_r   <= scan_r + 4'h1;
      scan_d_r <= scan_r;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_seen_r <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (ms_tick) tick_seen_r[i] <= 1'b1;
        else if (scan_d_r == 4'(i)) tick_seen_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filt_r <= '0;
      for (int i = 0; i < N_IN; i++) ms_cnt[i] <= '0;
    end else if (sync2_r[scan_d_r] == filt_r[scan_d_r]) begin
      ms_cnt[scan_d_r] <= '0;
    end else if (acc_hit) begin
      filt_r[scan_d_r] <= sync2_r[scan_d_r];
      ms_cnt[scan_d_r] <= '0;
    end else if (tick_seen_r[scan_d_r]) begin
      ms_cnt[scan_d_r] <= ms_cnt[scan_d_r] + 16'h0001;
    end
  end

  // Inversion after filtering, then pairing.
  logic [N_IN-1:0] rep, second_mask, dp_w;
  assign rep = filt_r ^ inv_r;

  for (genvar p = 0; p < NP; p++) begin : g_pair
    logic [1:0] dpv;
    ipf_pair u_pair (
      .first_input_of_pair  (rep[2*p]),
      .second_input_of_pair (rep[2*p+1]),
      .swap                 (swp_r[p]),
      .double_point_pair    (dpv)
    );
    assign dp_w[2*p+1:2*p]           = grp_r[p] ? dpv : 2'b00;
    assign second_mask[2*p+1:2*p]    = {grp_r[p], 1'b0};
  end

  logic [N_IN-1:0] single_nxt;
  assign single_nxt = rep & ~second_mask;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      single_state <= '0;
      dp_state     <= '0;
      state_chg    <= 1'b0;
    end else begin
      single_state <= single_nxt;
      dp_state     <= dp_w;
      state_chg    <= single_nxt != single_state || dp_w != dp_state;
    end
  end

  // Request answers: second input of a grouped pair is refused.
  logic req_err;
  assign req_err = req && req_idx[0] && grp_r[req_idx[3:1]];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp <= '0;
    end else begin
      resp.vld <= req;
      resp.err <= req_err;
      if (!req || req_err) resp.val <= 2'b00;
      else if (!req_idx[0] && grp_r[req_idx[3:1]]) resp.val <= dp_state[{req_idx[3:1], 1'b1} -: 2];
      else resp.val <= {1'b0, single_state[req_idx]};
    end
  end

  // Sticky events, cleared by writing one; a new event wins over the clear.
  logic [2:0] ev_stat_r, ev_set, ev_clr;
  assign ev_set = {resp.vld && resp.err, cfg_refused, state_chg};
  assign ev_clr = (reg_wr && hit(`IPF_OFF_ISTAT)) ? reg_wdata[2:0] : 3'b000;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ev_stat_r <= '0;
    else ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
  end
  assign irq = |(ev_stat_r & ev_mask_r);

  // Read data stand in the cycle after the strobe; filter words come from the store.
  logic        rd_q_r, rd_filt_r;
  logic [31:0] rd_word_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q_r    <= 1'b0;
      rd_filt_r <= 1'b0;
      rd_word_r <= '0;
    end else begin
      rd_q_r    <= reg_rd;
      rd_filt_r <= reg_rd && reg_addr >= `IPF_OFF_FILT_LO && reg_addr <= `IPF_OFF_FILT_HI;
      if (hit(`IPF_OFF_LINK_ADDR)) rd_word_r <= {16'h0000, cfg_r.link_addr};
      else if (hit(`IPF_OFF_TSYNC)) rd_word_r <= {16'h0000, cfg_r.tsync_s};
      else if (hit(`IPF_OFF_PKT_WAIT)) rd_word_r <= {23'h000000, cfg_r.pkt_wait};
      else if (hit(`IPF_OFF_BAUD)) rd_word_r <= {28'h0000000, cfg_r.baud};
      else if (hit(`IPF_OFF_FRAME))
        rd_word_r <= {22'h000000, cfg_r.ioa_size, 1'b0, cfg_r.cot2, cfg_r.ca2, cfg_r.la2,
                      cfg_r.stop2, cfg_r.parity};
      else if (hit(`IPF_OFF_INVERT)) rd_word_r <= {16'h0000, inv_r};
      else if (hit(`IPF_OFF_GROUP)) rd_word_r <= {24'h000000, grp_r};
      else if (hit(`IPF_OFF_SWAP)) rd_word_r <= {24'h000000, swp_r};
      else if (hit(`IPF_OFF_STATE)) rd_word_r <= {16'h0000, single_state};
      else if (hit(`IPF_OFF_DPAIR)) rd_word_r <= {16'h0000, dp_state};
      else if (hit(`IPF_OFF_ISTAT)) rd_word_r <= {29'h00000000, ev_stat_r};
      else if (hit(`IPF_OFF_IMASK)) rd_word_r <= {29'h00000000, ev_mask_r};
      else rd_word_r <= '0;
    end
  end
  assign reg_rdata = !rd_q_r ? '0 : rd_filt_r ? {16'h0000, filt_rd} : rd_word_r;

  // Checks.
  sequence s_grouped_second_req;
    req && req_idx[0] && grp_r[req_idx[3:1]];
  endsequence
  sequence s_err_answer;
    resp.vld && resp.err && resp.val == 2'b00;
  endsequence

  property p_second_err;
    @(posedge clk) disable iff (!nrst) s_grouped_second_req |=> s_err_answer;
  endproperty
  a_second_err: assert property (p_second_err) else $error("grouped second input not refused");

  property p_led_raw;
    @(posedge clk) disable iff (!nrst) $changed(inv_r) && $stable(sync2_r) |=> $stable(led);
  endproperty
  a_led_raw: assert property (p_led_raw) else $error("led moved with inversion");

  property p_pair_off;
    @(posedge clk) disable iff (!nrst)
      grp_r[0] && !swp_r[0] && rep[1:0] == 2'b01 |=> dp_state[1:0] == 2'b01;
  endproperty
  a_pair_off: assert property (p_pair_off) else $error("first input not off");

  property p_pair_swap;
    @(posedge clk) disable iff (!nrst)
      grp_r[0] && swp_r[0] && rep[1:0] == 2'b01 |=> dp_state[1:0] == 2'b10;
  endproperty
  a_pair_swap: assert property (p_pair_swap) else $error("swap not applied");

  property p_invert;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> (single_state & $past(inv_r & filt_r)) == 16'h0000;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted input reported active");

  property p_filter_hold;
    @(posedge clk) disable iff (!nrst) $changed(filt_r) |-> $past(acc_hit);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter output moved early");

  property p_la_refuse;
    @(posedge clk) disable iff (!nrst)
      reg_wr && hit(`IPF_OFF_LINK_ADDR) && reg_wdata[15:0] > `IPF_LINK_ADDR_1OCT && !cfg_r.la2
      |=> $stable(cfg_r.link_addr) ##1 ev_stat_r[`IPF_EV_CFG_REFUSED];
  endproperty
  a_la_refuse: assert property (p_la_refuse) else $error("wide link address taken");

  property p_tsync_zero;
    @(posedge clk) disable iff (!nrst)
      reg_wr && hit(`IPF_OFF_TSYNC) && reg_wdata[15:0] == 16'h0000 |=> cfg_r.tsync_s != '0;
  endproperty
  a_tsync_zero: assert property (p_tsync_zero) else $error("zero timeout taken");

  property p_pkt_wait;
    @(posedge clk) disable iff (!nrst)
      cfg_r.pkt_wait >= `IPF_MIN_PKT_WAIT && cfg_r.pkt_wait <= `IPF_MAX_PKT_WAIT;
  endproperty
  a_pkt_wait: assert property (p_pkt_wait) else $error("packet wait out of range");
endmodule

/* File: verification/ipf_master.sv */
// Master station model that issues state requests and collects the answers.
`timescale 1ns/1ps
module ipf_master (
  // Clock
  input  wire logic                clk,
  // Request side
  output logic                     req,
  output logic [3:0]               req_idx,
  input  wire ipf_pkg::ipf_resp_s  resp
);
  initial begin
    req     = 1'h0;
    req_idx = 4'h0;
  end

  // The answer stands for one cycle only, so it is taken just after that edge.
  task automatic ask(input logic [3:0] idx, output ipf_pkg::ipf_resp_s r);
    @(posedge clk);
    req     <= 1'h1;
    req_idx <= idx;
    @(posedge clk);
    req     <= 1'h0;
    #1 r = resp;
  endtask
endmodule

/* File: verification/ipf_top_tb.sv */
// Self-checking testbench of the input conditioning block.
`timescale 1ns/1ps
`include "ipf_regs.svh"
module ipf_top_tb;
  logic                     clk;
  logic                     nrst;
  logic [15:0]              din;
  logic [15:0]              led;
  logic [7:0]               reg_addr;
  logic [31:0]              reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [31:0]              reg_rdata;
  logic                     req;
  logic [3:0]               req_idx;
  ipf_pkg::ipf_resp_s       resp;
  logic [15:0]              single_state;
  logic [15:0]              dp_state;
  logic                     state_chg;
  ipf_pkg::ipf_link_cfg_s   link_cfg;
  logic                     irq;
  int                       failures;
  int                       compares;

  ipf_top #(.MS_CYCLES(32)) dut (
    .clk(clk), .nrst(nrst), .din(din), .led(led), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req(req), .req_idx(req_idx), .resp(resp), .single_state(single_state),
    .dp_state(dp_state), .state_chg(state_chg), .link_cfg(link_cfg), .irq(irq)
  );

  ipf_master master (.clk(clk), .req(req), .req_idx(req_idx), .resp(resp));

  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task automatic stop_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Every link setting and the first and last filter time must come back from reset at their defaults.
  task automatic t_defaults;
    logic [31:0] d;
    logic [7:0]  a[7];
    logic [31:0] e[7];
    a = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h7c};
    e = '{32'h1, 32'h12c, 32'h8, 32'h5, 32'h202, 32'h32, 32'h32};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d);
      chk(d, e[i]);
    end
    chk(32'(link_cfg.tsync_s), 32'h12c);
    rd(8'hfc, d);
    chk(d, 32'h0);
  endtask

  // Legal values are kept, illegal ones leave the old value and flag a refusal.
  task automatic t_config;
    logic [31:0] d;
    logic [7:0]  a[10];
    logic [31:0] w[10];
    logic [31:0] e[10];
    a = '{8'h00, 8'h10, 8'h00, 8'h10, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h10};
    w = '{32'h101, 32'h31b, 32'h101, 32'h30b, 32'h0, 32'h101, 32'h100, 32'hb,
          32'ha, 32'h31d};
    e = '{32'h1, 32'h31b, 32'h101, 32'h31b, 32'h12c, 32'h8, 32'h100, 32'h5,
          32'ha, 32'h31b};
    for (int i = 0; i < 10; i++) begin
      wr(a[i], w[i]);
      rd(a[i], d);
      chk(d, e[i]);
    end
    chk(32'(link_cfg.link_addr), 32'h101);
    chk(32'(link_cfg.ioa_size), 32'h3);
    rd(`IPF_OFF_ISTAT, d);
    chk(d & 32'h2, 32'h2);
    wr(`IPF_OFF_ISTAT, 32'h7);
  endtask

  // Inversion changes the reported state but never the indicator.
  task automatic t_invert;
    wr(`IPF_OFF_INVERT, 32'h8);
    for (int v = 0; v < 4; v++) begin
      din[3:2] <= 2'(v);
      repeat (40) @(posedge clk);
      chk(32'(single_state[3:2]), 32'(v ^ 2));
      chk(32'(led[3:2]), 32'(v));
    end
    wr(`IPF_OFF_INVERT, 32'h0);
  endtask

  // Pair coding in normal and swapped order, plus requests to both members.
  task automatic t_pair;
    ipf_pkg::ipf_resp_s r;
    logic [1:0]         e;
    wr(`IPF_OFF_GROUP, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(`IPF_OFF_SWAP, 32'(s));
      for (int v = 0; v < 4; v++) begin
        din[1:0] <= 2'(v);
        repeat (40) @(posedge clk);
        e = (s == 1) ? {v[0], v[1]} : {v[1], v[0]};
        chk(32'(dp_state[3:0]), 32'(e));
        master.ask(4'h0, r);
        chk(32'(r), {28'h0, 2'h2, e});
      end
    end
    wr(`IPF_OFF_IMASK, 32'h4);
    master.ask(4'h1, r);
    chk(32'(r), 32'hc);
    master.ask(4'h2, r);
    chk(32'(r), 32'h9);
    @(posedge clk);
    #1 chk(32'(irq), 32'h1);
    wr(`IPF_OFF_ISTAT, 32'h4);
    #1 chk(32'(irq), 32'h0);
    wr(`IPF_OFF_IMASK, 32'h0);
  endtask

  // Pulses shorter than the filter time never reach the reported state.
  task automatic t_filter;
    int n;
    wr(`IPF_OFF_IMASK, 32'h1);
    wr(`IPF_OFF_ISTAT, 32'h7);
    wr(8'h50, 32'h3);
    din[4] <= 1'h1;
    repeat (20) @(posedge clk);
    din[4] <= 1'h0;
    repeat (60) @(posedge clk);
    #1 chk(32'(single_state[4]), 32'h0);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    din[4] <= 1'h1;
    n = 0;
    while (single_state[4] !== 1'h1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n >= 60 && n <= 150), 32'h1);
    chk(32'(state_chg), 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(32'(irq), 32'h1);
    wr(`IPF_OFF_ISTAT, 32'h1);
    #1 chk(32'(irq), 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test;
  end

  initial begin
    clk       = 1'h0;
    nrst      = 1'h0;
    din       = 16'h0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    failures  = 0;
    compares  = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    t_defaults;
    t_config;
    for (int i = 0; i < 4; i++)
      wr(8'(`IPF_OFF_FILT_LO + 4 * i), 32'h0);
    t_invert;
    t_pair;
    t_filter;
    stop_test;
  end
endmodule
